/* core/lpt_map.svh */
// Register offsets, field positions, reset values and timing counts of the panel timing block
`ifndef LPT_MAP_SVH
`define LPT_MAP_SVH

// Register byte offsets
`define LPT_OFF_CTRL      8'h00
`define LPT_OFF_HCOUNT    8'h04
`define LPT_OFF_HSYNC     8'h08
`define LPT_OFF_VTOTAL    8'h0C
`define LPT_OFF_VACTIVE   8'h10
`define LPT_OFF_VSYNC     8'h14
`define LPT_OFF_PMGMT     8'h18
`define LPT_OFF_FBASE     8'h1C
`define LPT_OFF_FBASE_ACT 8'h20
`define LPT_OFF_STATUS    8'h24

// Field positions
`define LPT_CTRL_DON_BIT    0
`define LPT_CTRL_PWR_BIT    4
`define LPT_HTOTAL_LSB      16
`define LPT_HSW_LSB         16
`define LPT_VSW_LSB         16
`define LPT_ONA_LSB         0
`define LPT_ONB_LSB         4
`define LPT_POWER_OFF_DELAY_E_LSB        8
`define LPT_POWER_OFF_DELAY_F_LSB        12
`define LPT_POWER_STATE_LO_BIT        16
`define LPT_POWER_STATE_HI_BIT        17
`define LPT_FEND_BIT        0

// Reset values
`define LPT_RST_HTOTAL   8'h50
`define LPT_RST_HACTIVE  8'h3B
`define LPT_RST_HSW      4'h0
`define LPT_RST_HPOS     8'h46
`define LPT_RST_VTOTAL   11'h287
`define LPT_RST_VACTIVE  11'h27F
`define LPT_RST_VSW      4'h0
`define LPT_RST_VPOS     11'h285
`define LPT_RST_ONA      4'h1
`define LPT_RST_ONB      4'h6
`define LPT_RST_POWER_OFF_DELAY_E     4'h6
`define LPT_RST_POWER_OFF_DELAY_F     4'h1

// Timing counts and bus response codes
`define LPT_DOTS_PER_CHAR 8
`define LPT_VSYNC_OFFSET  2
`define LPT_RESP_OKAY     2'h0
`define LPT_RESP_SLVERR   2'h2

`endif

/* core/lpt_pkg.sv */
// Types shared by the panel timing block
package lpt_pkg;

  // Power sequencer states
  typedef enum logic [2:0] {
    LPT_PWR_IDLE  = 3'b000,
    LPT_PWR_ON_A  = 3'b001,
    LPT_PWR_ON_B  = 3'b010,
    LPT_PWR_RUN   = 3'b011,
    LPT_PWR_OFF_E = 3'b100,
    LPT_PWR_OFF_F = 3'b101
  } lpt_pwr_t;

  typedef logic [31:0] lpt_word_t;

endpackage : lpt_pkg

/* core/lpt_axil_slave.sv */
// AXI4-Lite slave front end of the panel timing registers
`timescale 1ns/10ps
`include "lpt_map.svh"
module lpt_axil_slave #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // Write address and data
  input  wire logic [AW-1:0]     s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  input  wire lpt_pkg::lpt_word_t s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  // Write response
  output logic [1:0]             s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  // Read address and data
  input  wire logic [AW-1:0]     s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  output lpt_pkg::lpt_word_t     s_axil_rdata,
  output logic [1:0]             s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  // Register file side
  output logic                   wr_pulse,
  output logic [AW-1:0]          wr_addr,
  output lpt_pkg::lpt_word_t     wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_hit,
  output logic [AW-1:0]          rd_addr,
  input  wire lpt_pkg::lpt_word_t rd_data,
  input  wire logic              rd_hit
);
  import lpt_pkg::*;

  logic aw_held;                      // Address captured, waiting for data
  logic w_held;                       // Data captured, waiting for address

  // Ready only while the half is not held and no response is pending
  assign s_axil_awready = ~aw_held & ~s_axil_bvalid & ~wr_pulse;
  assign s_axil_wready  = ~w_held & ~s_axil_bvalid & ~wr_pulse;
  assign s_axil_arready = ~s_axil_rvalid;
  assign rd_addr        = s_axil_araddr;

  // Write halves taken in either order
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axil_wdata;
        wr_strb <= s_axil_wstrb;
      end
    end
  end

  // One-cycle write strobe once both halves are in
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_pulse <= 1'b0;
    end else begin
      wr_pulse <= aw_held & w_held;
    end
  end

  // Write response follows the strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= `LPT_RESP_OKAY;
    end else if (wr_pulse) begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp  <= wr_hit ? `LPT_RESP_OKAY : `LPT_RESP_SLVERR;
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  // Read data captured at the address handshake
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= '0;
      s_axil_rresp  <= `LPT_RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rdata  <= rd_hit ? rd_data : '0;
      s_axil_rresp  <= rd_hit ? `LPT_RESP_OKAY : `LPT_RESP_SLVERR;
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

endmodule : lpt_axil_slave

/* core/lpt_top.sv */
// Panel sync timing generator and panel power sequencer
//
// Operation
// - Line length in 8-dot chars minus one
// - Active width in 8-dot chars minus one
// - Hsync width in 8-dot chars minus one
// - Narrowest hsync pulse is eight dots
// - Hsync start from width plus porch, minus one
// - Frame length in lines minus one
// - Visible lines minus one
// - Vsync width in lines minus one
// - Vsync start from visible plus porch, minus two
// - Syncs and RGB run before power control rises
// - After power control falls, wait frames, then stop
// - New frame base applies at next frame end
// - Fetch uses the active copy of the upper fetch base register
`timescale 1ns/10ps
`include "lpt_map.svh"
module lpt_top #(
  parameter int AW = 8,
  parameter int HW = 8,
  parameter int VW = 11,
  parameter int PW = 16
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rstn,
  // Register bus
  input  wire logic [AW-1:0]      s_axil_awaddr,
  input  wire logic               s_axil_awvalid,
  output logic                    s_axil_awready,
  input  wire lpt_pkg::lpt_word_t s_axil_wdata,
  input  wire logic [3:0]         s_axil_wstrb,
  input  wire logic               s_axil_wvalid,
  output logic                    s_axil_wready,
  output logic [1:0]              s_axil_bresp,
  output logic                    s_axil_bvalid,
  input  wire logic               s_axil_bready,
  input  wire logic [AW-1:0]      s_axil_araddr,
  input  wire logic               s_axil_arvalid,
  output logic                    s_axil_arready,
  output lpt_pkg::lpt_word_t      s_axil_rdata,
  output logic [1:0]              s_axil_rresp,
  output logic                    s_axil_rvalid,
  input  wire logic               s_axil_rready,
  // Dot clock from the panel side
  input  wire logic               dot_clk,
  // Pixel data from the fetch path
  input  wire logic [PW-1:0]      pix_data,
  output logic [31:0]             fetch_base,
  // Panel pins
  output logic                    lcd_hsync_n,
  output logic                    lcd_vsync_n,
  output logic                    lcd_de,
  output logic [PW-1:0]           lcd_rgb,
  output logic                    panel_power_ctrl,
  output logic                    panel_reset_n,
  // Frame end request
  output logic                    frame_irq
);
  import lpt_pkg::*;

  // Bus side wires
  logic            wr_pulse;
  logic [AW-1:0]   wr_addr;
  lpt_word_t       wr_data;
  logic [3:0]      wr_strb;
  logic            wr_hit;
  logic [AW-1:0]   rd_addr;
  lpt_word_t       rd_data;
  logic            rd_hit;

  // Software registers
  logic [1:0]      ctrl_reg;            // Power enable and display on
  logic [HW-1:0]   h_total_chars;
  logic [HW-1:0]   h_active_chars;
  logic [3:0]      h_sync_width;
  logic [HW-1:0]   h_sync_position;
  logic [VW-1:0]   v_total_lines;
  logic [VW-1:0]   v_active_lines;
  logic [3:0]      v_sync_width;
  logic [VW-1:0]   v_sync_position;
  logic [3:0]      power_on_delay_a;
  logic [3:0]      power_on_delay_b;
  logic [3:0]      power_off_delay_e;
  logic [3:0]      power_off_delay_f;
  logic [31:0]     upper_fetch_base_reg;
  logic            base_pend_reg;       // Written base not yet applied
  logic            frame_end_flag;

  // Timing state
  logic            dclk_s1, dclk_s2, dclk_s3;
  logic            dot_en;
  logic [2:0]      dot_cnt;
  logic [HW-1:0]   hchar_cnt;
  logic [VW-1:0]   line_cnt;
  logic            frame_end;
  logic            line_end;
  logic            tim_run;
  logic            out_en;              // Syncs and RGB driven to panel
  logic            power_state_hi;
  logic            power_state_lo;
  lpt_pwr_t        pwr_reg, pwr_next;
  logic [4:0]      frm_cnt;
  logic [4:0]      frm_goal;
  logic            frm_done;

  // Bus front end
  lpt_axil_slave #(.AW(AW)) u_slave (
    .mclk           (mclk),
    .rstn           (rstn),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .wr_pulse       (wr_pulse),
    .wr_addr        (wr_addr),
    .wr_data        (wr_data),
    .wr_strb        (wr_strb),
    .wr_hit         (wr_hit),
    .rd_addr        (rd_addr),
    .rd_data        (rd_data),
    .rd_hit         (rd_hit)
  );

  // Byte lane merge of a write into an old word
  function automatic lpt_word_t merge(input lpt_word_t old_w, input lpt_word_t new_w,
                                      input logic [3:0] strb);
    lpt_word_t res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Current register images, shared by read and write paths
  lpt_word_t img_ctrl, img_hcnt, img_hsync, img_vtot, img_vact, img_vsync, img_pm;
  always_comb begin
    img_ctrl  = '0;
    img_ctrl[`LPT_CTRL_DON_BIT] = ctrl_reg[0];
    img_ctrl[`LPT_CTRL_PWR_BIT] = ctrl_reg[1];
    img_hcnt  = '0;
    img_hcnt[`LPT_HTOTAL_LSB +: HW] = h_total_chars;
    img_hcnt[HW-1:0]                = h_active_chars;
    img_hsync = '0;
    img_hsync[`LPT_HSW_LSB +: 4]    = h_sync_width;
    img_hsync[HW-1:0]               = h_sync_position;
    img_vtot  = '0;
    img_vtot[VW-1:0]                = v_total_lines;
    img_vact  = '0;
    img_vact[VW-1:0]                = v_active_lines;
    img_vsync = '0;
    img_vsync[`LPT_VSW_LSB +: 4]    = v_sync_width;
    img_vsync[VW-1:0]               = v_sync_position;
    img_pm    = '0;
    img_pm[`LPT_ONA_LSB +: 4]       = power_on_delay_a;
    img_pm[`LPT_ONB_LSB +: 4]       = power_on_delay_b;
    img_pm[`LPT_POWER_OFF_DELAY_E_LSB +: 4]      = power_off_delay_e;
    img_pm[`LPT_POWER_OFF_DELAY_F_LSB +: 4]      = power_off_delay_f;
    img_pm[`LPT_POWER_STATE_LO_BIT]           = power_state_lo;
    img_pm[`LPT_POWER_STATE_HI_BIT]           = power_state_hi;
  end

  // Read decode; unmapped offsets answer with an error
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = '0;
    case (rd_addr)
      `LPT_OFF_CTRL:      rd_data = img_ctrl;
      `LPT_OFF_HCOUNT:    rd_data = img_hcnt;
      `LPT_OFF_HSYNC:     rd_data = img_hsync;
      `LPT_OFF_VTOTAL:    rd_data = img_vtot;
      `LPT_OFF_VACTIVE:   rd_data = img_vact;
      `LPT_OFF_VSYNC:     rd_data = img_vsync;
      `LPT_OFF_PMGMT:     rd_data = img_pm;
      `LPT_OFF_FBASE:     rd_data = upper_fetch_base_reg;
      `LPT_OFF_FBASE_ACT: rd_data = fetch_base;
      `LPT_OFF_STATUS:    rd_data = {31'h0, frame_end_flag};
      default:            rd_hit  = 1'b0;
    endcase
  end

  // Write decode and lane merge; the active base copy is read only
  lpt_word_t wr_word;                   // Addressed image with written lanes
  always_comb begin
    wr_hit  = 1'b1;
    wr_word = '0;
    case (wr_addr)
      `LPT_OFF_CTRL:    wr_word = merge(img_ctrl, wr_data, wr_strb);
      `LPT_OFF_HCOUNT:  wr_word = merge(img_hcnt, wr_data, wr_strb);
      `LPT_OFF_HSYNC:   wr_word = merge(img_hsync, wr_data, wr_strb);
      `LPT_OFF_VTOTAL:  wr_word = merge(img_vtot, wr_data, wr_strb);
      `LPT_OFF_VACTIVE: wr_word = merge(img_vact, wr_data, wr_strb);
      `LPT_OFF_VSYNC:   wr_word = merge(img_vsync, wr_data, wr_strb);
      `LPT_OFF_PMGMT:   wr_word = merge(img_pm, wr_data, wr_strb);
      `LPT_OFF_FBASE, `LPT_OFF_STATUS: wr_hit = 1'b1;
      default:          wr_hit  = 1'b0;
    endcase
  end

  // Timing and power registers; merged word keeps unwritten lanes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg          <= 2'h0;
      h_total_chars     <= `LPT_RST_HTOTAL;
      h_active_chars    <= `LPT_RST_HACTIVE;
      h_sync_width      <= `LPT_RST_HSW;
      h_sync_position   <= `LPT_RST_HPOS;
      v_total_lines     <= `LPT_RST_VTOTAL;
      v_active_lines    <= `LPT_RST_VACTIVE;
      v_sync_width      <= `LPT_RST_VSW;
      v_sync_position   <= `LPT_RST_VPOS;
      power_on_delay_a  <= `LPT_RST_ONA;
      power_on_delay_b  <= `LPT_RST_ONB;
      power_off_delay_e <= `LPT_RST_POWER_OFF_DELAY_E;
      power_off_delay_f <= `LPT_RST_POWER_OFF_DELAY_F;
    end else if (wr_pulse) begin
      case (wr_addr)
        // Start and stop codes only; other values are not guarded
        `LPT_OFF_CTRL: begin
          ctrl_reg[0] <= wr_word[`LPT_CTRL_DON_BIT];
          ctrl_reg[1] <= wr_word[`LPT_CTRL_PWR_BIT];
        end
        `LPT_OFF_HCOUNT: begin
          h_total_chars  <= wr_word[`LPT_HTOTAL_LSB +: HW];
          h_active_chars <= wr_word[HW-1:0];
        end
        `LPT_OFF_HSYNC: begin
          h_sync_width    <= wr_word[`LPT_HSW_LSB +: 4];
          h_sync_position <= wr_word[HW-1:0];
        end
        `LPT_OFF_VTOTAL:  v_total_lines  <= wr_word[VW-1:0];
        `LPT_OFF_VACTIVE: v_active_lines <= wr_word[VW-1:0];
        `LPT_OFF_VSYNC: begin
          v_sync_width    <= wr_word[`LPT_VSW_LSB +: 4];
          v_sync_position <= wr_word[VW-1:0];
        end
        `LPT_OFF_PMGMT: begin
          power_on_delay_a  <= wr_word[`LPT_ONA_LSB +: 4];
          power_on_delay_b  <= wr_word[`LPT_ONB_LSB +: 4];
          power_off_delay_e <= wr_word[`LPT_POWER_OFF_DELAY_E_LSB +: 4];
          power_off_delay_f <= wr_word[`LPT_POWER_OFF_DELAY_F_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // Frame base: software copy plus pending mark
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      upper_fetch_base_reg <= 32'h0;
      base_pend_reg        <= 1'b0;
    end else if (wr_pulse && wr_addr == `LPT_OFF_FBASE) begin
      upper_fetch_base_reg <= merge(upper_fetch_base_reg, wr_data, wr_strb);
      base_pend_reg        <= 1'b1;
    end else if (frame_end) begin
      base_pend_reg        <= 1'b0;
    end
  end

  // Active base moves only at a frame end, never mid-frame
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fetch_base <= 32'h0;
    end else if (frame_end && base_pend_reg) begin
      fetch_base <= upper_fetch_base_reg;
    end
  end

  // Sticky frame end flag; a new frame end beats the clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      frame_end_flag <= 1'b0;
      frame_irq      <= 1'b0;
    end else begin
      if (frame_end) begin
        frame_end_flag <= 1'b1;
        frame_irq      <= 1'b1;
      end else if (wr_pulse && wr_addr == `LPT_OFF_STATUS && wr_strb[0]
                   && wr_data[`LPT_FEND_BIT]) begin
        frame_end_flag <= 1'b0;
        frame_irq      <= 1'b0;
      end
    end
  end

  // Dot clock synchroniser; the second and third stages feed the edge detect
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dclk_s1 <= 1'b0;
      dclk_s2 <= 1'b0;
      dclk_s3 <= 1'b0;
    end else begin
      dclk_s1 <= dot_clk;
      dclk_s2 <= dclk_s1;
      dclk_s3 <= dclk_s2;
    end
  end
  assign dot_en = dclk_s2 & ~dclk_s3;

  // Counters advance on each dot and in eight-dot chars
  assign line_end  = dot_en && dot_cnt == 3'(`LPT_DOTS_PER_CHAR - 1)
                     && hchar_cnt == h_total_chars;
  assign frame_end = line_end && line_cnt == v_total_lines;
  assign tim_run   = pwr_reg != LPT_PWR_IDLE;

  // Dot and char position within the line
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dot_cnt   <= 3'h0;
      hchar_cnt <= '0;
    end else if (!tim_run) begin
      dot_cnt   <= 3'h0;
      hchar_cnt <= '0;
    end else if (dot_en) begin
      dot_cnt <= dot_cnt + 3'h1;
      if (dot_cnt == 3'(`LPT_DOTS_PER_CHAR - 1)) begin
        hchar_cnt <= line_end ? '0 : hchar_cnt + 1'b1;
      end
    end
  end

  // Line position within the frame
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      line_cnt <= '0;
    end else if (!tim_run) begin
      line_cnt <= '0;
    end else if (line_end) begin
      line_cnt <= frame_end ? '0 : line_cnt + 1'b1;
    end
  end

  // Panel outputs, all from flops; held idle while output is stopped
  logic h_vis, v_vis, h_sync_on, v_sync_on;
  logic [HW:0] hs_start;
  logic [VW:0] vs_start;
  assign hs_start  = {1'b0, h_sync_position} + 1'b1;
  assign vs_start  = {1'b0, v_sync_position} + (VW+1)'(`LPT_VSYNC_OFFSET);
  assign h_vis     = hchar_cnt <= h_active_chars;
  assign v_vis     = line_cnt <= v_active_lines;
  // Whole chars only, so a zero width still gives eight dots
  assign h_sync_on = {1'b0, hchar_cnt} >= hs_start
                     && {1'b0, hchar_cnt} <= hs_start + (HW+1)'(h_sync_width);
  assign v_sync_on = {1'b0, line_cnt} >= vs_start
                     && {1'b0, line_cnt} <= vs_start + (VW+1)'(v_sync_width);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lcd_hsync_n <= 1'b1;
      lcd_vsync_n <= 1'b1;
      lcd_de      <= 1'b0;
      lcd_rgb     <= '0;
    end else begin
      lcd_hsync_n <= ~(out_en & h_sync_on);
      lcd_vsync_n <= ~(out_en & v_sync_on);
      lcd_de      <= out_en & h_vis & v_vis;
      lcd_rgb     <= (out_en & h_vis & v_vis) ? pix_data : '0;
    end
  end

  // Frame counting for the power delays; goal is field plus one frames
  assign frm_done = frame_end && frm_cnt == frm_goal;
  always_comb begin
    case (pwr_reg)
      LPT_PWR_ON_A:  frm_goal = {1'b0, power_on_delay_a};
      LPT_PWR_ON_B:  frm_goal = {1'b0, power_on_delay_b};
      LPT_PWR_OFF_E: frm_goal = {1'b0, power_off_delay_e};
      LPT_PWR_OFF_F: frm_goal = {1'b0, power_off_delay_f};
      default:       frm_goal = 5'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      frm_cnt <= 5'h0;
    end else if (pwr_reg != pwr_next) begin
      frm_cnt <= 5'h0;
    end else if (frame_end) begin
      frm_cnt <= frm_cnt + 5'h1;
    end
  end

  // Power sequence steps
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      LPT_PWR_IDLE:  if (ctrl_reg[0]) pwr_next = LPT_PWR_ON_A;
      LPT_PWR_ON_A:  if (frm_done) pwr_next = LPT_PWR_ON_B;
      LPT_PWR_ON_B:  if (frm_done) pwr_next = LPT_PWR_RUN;
      LPT_PWR_RUN:   if (!ctrl_reg[0]) pwr_next = LPT_PWR_OFF_E;
      LPT_PWR_OFF_E: if (frm_done) pwr_next = LPT_PWR_OFF_F;
      LPT_PWR_OFF_F: if (frm_done) pwr_next = LPT_PWR_IDLE;
      default:       pwr_next = LPT_PWR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pwr_reg <= LPT_PWR_IDLE;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // Pin levels per step; power control rises after output runs and reset is released
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      out_en           <= 1'b0;
      panel_power_ctrl <= 1'b0;
      panel_reset_n    <= 1'b0;
      power_state_lo   <= 1'b0;
      power_state_hi   <= 1'b0;
    end else begin
      out_en           <= pwr_next inside {LPT_PWR_ON_B, LPT_PWR_RUN, LPT_PWR_OFF_E};
      panel_power_ctrl <= pwr_next == LPT_PWR_RUN && out_en && panel_reset_n;
      panel_reset_n    <= pwr_next inside {LPT_PWR_RUN, LPT_PWR_OFF_E};
      power_state_lo   <= pwr_next inside {LPT_PWR_ON_B, LPT_PWR_RUN, LPT_PWR_OFF_E};
      power_state_hi   <= pwr_next == LPT_PWR_RUN;
    end
  end

endmodule : lpt_top

/* dv/lpt_chk.sv */
// Port checker for the panel timing block
`timescale 1ns/10ps
module lpt_chk #(parameter int PW = 16) (
  // Clock, reset, bus
  input wire logic mclk,
  input wire logic rstn,
  input wire logic s_axil_bvalid,
  // Panel side
  input wire logic [31:0] fetch_base,
  input wire logic lcd_hsync_n,
  input wire logic lcd_vsync_n,
  input wire logic lcd_de,
  input wire logic [PW-1:0] lcd_rgb,
  input wire logic panel_power_ctrl,
  input wire logic panel_reset_n,
  input wire logic frame_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Sync seen since reset; power control must not rise first
  logic hs_seen_reg;
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) hs_seen_reg <= 1'b0;
    else if (!lcd_hsync_n) hs_seen_reg <= 1'b1;
  rgb_blank_a: assert property (!lcd_de |-> lcd_rgb == '0)
    else $error("rgb not blank");
  de_sync_a: assert property (lcd_de |-> lcd_hsync_n && lcd_vsync_n)
    else $error("de inside sync");
  on_order_a: assert property ($rose(panel_power_ctrl) |-> hs_seen_reg && $past(panel_reset_n))
    else $error("power on order");
  off_order_a: assert property ($fell(panel_reset_n) |-> !panel_power_ctrl)
    else $error("power off order");
  hs_width_a: assert property ($fell(lcd_hsync_n) |=> !lcd_hsync_n [*8])
    else $error("hsync too short");
  vs_width_a: assert property ($fell(lcd_vsync_n) |=> !lcd_vsync_n [*8])
    else $error("vsync too short");
  irq_hold_a: assert property ($fell(frame_irq) |-> s_axil_bvalid || $past(s_axil_bvalid))
    else $error("flag lost");
  base_frame_a: assert property ($changed(fetch_base) |-> ##[0:2] frame_irq)
    else $error("base changed mid frame");
  cover property ($rose(panel_power_ctrl));
  cover property ($fell(panel_reset_n));
  cover property ($changed(fetch_base));
endmodule : lpt_chk
bind lpt_top lpt_chk #(.PW(PW)) i_chk (.mclk, .rstn, .s_axil_bvalid, .fetch_base,
  .lcd_hsync_n, .lcd_vsync_n, .lcd_de, .lcd_rgb, .panel_power_ctrl, .panel_reset_n,
  .frame_irq);

/* dv/lpt_panel.sv */
// Panel model: dot clock source and timing meter
`timescale 1ns/10ps
module lpt_panel (
  // Panel pins
  output logic dot_clk,
  input wire logic lcd_hsync_n,
  input wire logic lcd_vsync_n,
  input wire logic lcd_de,
  // Measured dots and lines
  output int de_dots,
  output int line_dots,
  output int frame_lines,
  output int hs_dots
);
  int de_c, ln_c, fr_c, hs_c;
  logic de_q = 1'b0, hs_q = 1'b1, vs_q = 1'b1;
  // Runs free: the sequencer counts frames while output is off
  initial dot_clk = 1'b0;
  always #100 dot_clk = ~dot_clk;
  // Pins settle mid period, so the rising edge samples cleanly
  always @(posedge dot_clk) begin
    de_c <= lcd_de ? de_c + 1 : 0;
    hs_c <= lcd_hsync_n ? 0 : hs_c + 1;
    if (!hs_q && lcd_hsync_n) hs_dots <= hs_c;
    if (de_q && !lcd_de) de_dots <= de_c;
    ln_c <= (hs_q && !lcd_hsync_n) ? 1 : ln_c + 1;
    if (hs_q && !lcd_hsync_n) line_dots <= ln_c;
    if (hs_q && !lcd_hsync_n) fr_c <= fr_c + 1;
    if (vs_q && !lcd_vsync_n) frame_lines <= fr_c;
    if (vs_q && !lcd_vsync_n) fr_c <= 0;
    de_q <= lcd_de;
    hs_q <= lcd_hsync_n;
    vs_q <= lcd_vsync_n;
  end
endmodule : lpt_panel

/* dv/tb.sv */
// Self-checking bench for the panel timing block
`timescale 1ns/10ps
module tb;
  import lpt_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, dot_clk;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, s_axil_awready, s_axil_wready;
  logic s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [3:0] s_axil_wstrb = 4'hF;
  logic [1:0] s_axil_bresp, s_axil_rresp, rsp;
  lpt_word_t s_axil_wdata = 32'h0, s_axil_rdata, rd_w;
  logic [15:0] pix_data = 16'h0, lcd_rgb;
  logic [31:0] fetch_base;
  logic lcd_hsync_n, lcd_vsync_n, lcd_de, panel_power_ctrl, panel_reset_n, frame_irq;
  int de_dots, line_dots, frame_lines, hs_dots, mismatches = 0, total_checks = 0, ht, hp, vt, n;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) pix_data <= 16'($urandom);
  lpt_top i_dut (.*);
  lpt_panel i_pnl (.*);
  // Dots of a span programmed as chars minus one
  function automatic lpt_word_t dots(input int chars);
    return 32'((chars + 1) * 8);
  endfunction : dots
  task automatic chk(input lpt_word_t got, input lpt_word_t exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Write: both halves offered together, bready held until bvalid
  task automatic wr(input logic [7:0] a, input lpt_word_t d);
    @(posedge mclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1);
    rsp = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1);
    rd_w = s_axil_rdata;
    rsp = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask : rd
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // Hang guard, well beyond the expected fifteen or so frames
  initial begin
    #(90000 * 25);
    mismatches++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h35b3));
    ht = $urandom_range(4, 3);
    hp = $urandom_range(ht - 2, 1);
    vt = $urandom_range(5, 3);
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h04);
    chk(rd_w, 32'h0050003B);
    rd(8'h14);
    chk(rd_w, 32'h00000285);
    rd(8'h3C);
    chk({30'h0, rsp}, 32'h00000002);
    wr(8'h3C, 32'hFFFFFFFF);
    chk({30'h0, rsp}, 32'h00000002);
    wr(8'h04, {8'h00, 8'(ht), 16'h0001});
    wr(8'h08, {24'h000000, 8'(hp)});
    wr(8'h0C, 32'(vt));
    wr(8'h10, 32'h00000000);
    wr(8'h14, 32'h00000000);
    wr(8'h18, 32'h00001161);
    wr(8'h1C, 32'h00010000);
    wr(8'h00, 32'h00000011);
    wait (panel_power_ctrl === 1'b1);
    repeat (3) @(negedge lcd_vsync_n);
    chk(de_dots, dots(1));
    chk(line_dots, dots(ht));
    chk(frame_lines, 32'(vt + 1));
    chk(hs_dots, dots(0));
    chk(fetch_base, 32'h00010000);
    wr(8'h24, 32'h00000001);
    repeat (5) @(posedge mclk);
    wr(8'h1C, 32'h00020000);
    chk(fetch_base, 32'h00010000);
    @(posedge frame_irq);
    repeat (50) @(posedge mclk);
    chk(fetch_base, 32'h00020000);
    chk({31'h0, frame_irq}, 32'h00000001);
    rd(8'h18);
    chk(32'(rd_w[17:16]), 32'h00000003);
    wr(8'h00, 32'h00000000);
    wait (panel_power_ctrl === 1'b0);
    chk({31'h0, panel_reset_n}, 32'h00000001);
    n = 0;
    while (panel_reset_n === 1'b1) begin
      @(negedge lcd_vsync_n or negedge panel_reset_n);
      if (panel_reset_n === 1'b1) n++;
    end
    chk({31'h0, n == 2 || n == 3}, 32'h00000001);
    rd(8'h18);
    chk(32'(rd_w[17:16]), 32'h00000000);
    report_and_stop();
  end
endmodule : tb
